// [src/sstop_pkg.sv]
// Package for the standby stop and idle controller
package sstop_pkg;
	// Register byte offsets
	localparam logic [11:0] SSTOP_MODE_OFS   = 12'h000; // power_save_mode_reg
	localparam logic [11:0] SSTOP_CTRL_OFS   = 12'h004; // power_save_control_reg
	localparam logic [11:0] SSTOP_STATUS_OFS = 12'h008;
	localparam logic [11:0] SSTOP_CLKSEL_OFS = 12'h00c;
	localparam logic [11:0] SSTOP_ADC_OFS    = 12'h010; // adc_mode_reg
	localparam logic [11:0] SSTOP_RTO_OFS    = 12'h014;
	// power_save_mode_reg fields
	localparam int SSTOP_STANDBY_SELECT_BIT = 0;
	localparam int SSTOP_IDLE_SELECT_BIT    = 1;
	// power_save_control_reg fields
	localparam int SSTOP_STOP_REQUEST_BIT   = 1;
	localparam int SSTOP_IDLE_REQUEST_BIT   = 2;
	localparam int SSTOP_MASKABLE_DIS_BIT   = 4;
	localparam int SSTOP_PIN_NMI_DIS_BIT    = 5;
	localparam int SSTOP_WDT_NMI_DIS_BIT    = 6;
	// Clock select fields
	localparam int SSTOP_CPU_ON_SUB_BIT     = 0;
	localparam int SSTOP_ASYNC_EXT_BIT      = 1;
	localparam int SSTOP_CSI_EXT_BIT        = 2;
	localparam int SSTOP_TIMER_EN_BIT       = 3;
	// ADC mode fields
	localparam int SSTOP_ADC_CONV_BIT       = 0;
	localparam int SSTOP_ADC_REF_BIT        = 1;
	// Reset values
	localparam logic [31:0] SSTOP_ZERO_WORD = 32'h0000_0000;
	// Counts
	localparam int SSTOP_EXT_IRQ_N = 7;
	localparam int SSTOP_PERIPH_IRQ_N = 8;
	localparam int SSTOP_OSC_WAIT_US = 1;
	localparam int SSTOP_CLK_MHZ = 200;
	localparam int SSTOP_OSC_WAIT_CYC = SSTOP_OSC_WAIT_US * SSTOP_CLK_MHZ;
	localparam logic [3:0] SSTOP_PRIO_NONE = 4'hf;
	// Power state, one-hot
	typedef enum logic [3:0] {
		SSTOP_RUN  = 4'h1,
		SSTOP_STOP = 4'h2,
		SSTOP_WAIT = 4'h4,
		SSTOP_IDLE = 4'h8
	} sstop_state_t;
	// Gated clock enables
	typedef struct packed {
		logic main_osc_en;
		logic sub_osc_en;
		logic cpu_clk_en;
		logic periph_clk_en;
	} sstop_clk_t;
	// Wake report to the CPU
	typedef struct packed {
		logic       ack;
		logic       to_nmi_handler;
		logic       to_handler;
		logic       next_instr;
	} sstop_wake_t;
endpackage

// [src/sstop_ctrl.sv]
// Standby controller: STOP/IDLE entry, wake decision, clock gating
// Notes on behaviour
// - STOP needs standby select and stop write
// - STOP halts main oscillator, subclock runs
// - STOP cuts CPU and peripheral clocks
// - RAM contents kept across STOP
// - Subclock or external peripherals keep running
// - Wake on NMI pin, pins, peripherals, reset
// - Watchdog sources count only on subclock
// - Resume from STOP only after oscillator wait; IDLE resumes at once
// - Wake regardless of request priority
// - Lower priority wakes but stays pending
// - Higher priority wakes and is acknowledged
// - NMI wake branches to its handler
// - Maskable wake branches or continues per enable
// - Disabled source never wakes
// - RTO buffers frozen while CPU stopped
// - Port state held during IDLE
// - Internal data held during IDLE
// - Async channel runs in IDLE only external
// - Clocked serial runs in IDLE only external
// - Reset wake equals ordinary reset
`timescale 1ns/1ps
module sstop_ctrl
	import sstop_pkg::*;
#(
	parameter int OSC_WAIT_CYC = SSTOP_OSC_WAIT_CYC
) (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Wake sources from pins
	input  wire logic                          nmi_pin,
	input  wire logic [SSTOP_EXT_IRQ_N-1:0]    external_irq_pins,
	input  wire logic                          reset_pin_n,
	// Wake sources from logic
	input  wire logic [SSTOP_PERIPH_IRQ_N-1:0] periph_irq,
	input  wire logic                          second_watchdog_irq,
	input  wire logic                          second_watchdog_reset,
	// CPU interrupt context
	input  wire logic [3:0]                    req_prio,
	input  wire logic [3:0]                    serviced_prio,
	input  wire logic                          interrupts_enabled_state,
	// Clock control and status
	output sstop_clk_t                         clk_ctl,
	output sstop_wake_t                        wake,
	output logic                               standby_reset,
	output logic                               hold_state,
	output logic                               rto_update_en,
	output logic                               first_async_channel_en,
	output logic                               clocked_serial_channels_en
);

	// Registers
	logic [1:0]   power_save_mode_reg;
	logic [6:0]   power_save_control_reg;
	logic [3:0]   clk_select;
	logic [1:0]   adc_mode_reg;
	sstop_state_t state;
	sstop_state_t next_state;
	logic [15:0]  wait_cnt;
	logic         stop_from_isr;
	logic [3:0]   entry_prio;

	// Synchronisers for pin inputs
	logic [1:0] nmi_s;
	logic [1:0] rst_s;
	logic [SSTOP_EXT_IRQ_N-1:0] ext_s0;
	logic [SSTOP_EXT_IRQ_N-1:0] ext_s1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_s  <= 2'h0;
			rst_s  <= 2'h3;
			ext_s0 <= '0;
			ext_s1 <= '0;
		end else begin
			nmi_s  <= {nmi_s[0], nmi_pin};
			rst_s  <= {rst_s[0], reset_pin_n};
			ext_s0 <= external_irq_pins;
			ext_s1 <= ext_s0;
		end
	end

	// Wake source qualification
	logic on_sub;
	logic nmi_src;
	logic mask_src;
	logic reset_src;
	logic wake_any;
	logic apb_wr;
	logic stop_wr;
	logic idle_wr;
	assign on_sub = clk_select[SSTOP_CPU_ON_SUB_BIT];
	assign nmi_src = (nmi_s[1] & ~power_save_control_reg[SSTOP_PIN_NMI_DIS_BIT]) |
		(second_watchdog_irq & on_sub & ~power_save_control_reg[SSTOP_WDT_NMI_DIS_BIT]);
	assign mask_src = ~power_save_control_reg[SSTOP_MASKABLE_DIS_BIT] & ((|ext_s1) | (|periph_irq));
	assign reset_src = ~rst_s[1] | (second_watchdog_reset & on_sub);
	assign wake_any = nmi_src | mask_src;

	// APB write decode
	assign apb_wr  = psel & penable & pwrite;
	assign stop_wr = apb_wr && paddr == SSTOP_CTRL_OFS && pwdata[SSTOP_STOP_REQUEST_BIT]
		&& power_save_mode_reg[SSTOP_STANDBY_SELECT_BIT];
	assign idle_wr = apb_wr && paddr == SSTOP_CTRL_OFS && pwdata[SSTOP_IDLE_REQUEST_BIT]
		&& power_save_mode_reg[SSTOP_IDLE_SELECT_BIT];

	// Next state; request bits are one-shot, so nothing re-enters by itself
	always_comb begin
		next_state = state;
		case (state)
			SSTOP_RUN: begin
				if (stop_wr)
					next_state = SSTOP_STOP;
				else if (idle_wr)
					next_state = SSTOP_IDLE;
			end
			SSTOP_STOP: begin
				if (wake_any)
					next_state = SSTOP_WAIT;
			end
			SSTOP_WAIT: begin
				if (wait_cnt == 16'(OSC_WAIT_CYC - 1))
					next_state = SSTOP_RUN;
			end
			SSTOP_IDLE: begin
				if (wake_any)
					next_state = SSTOP_RUN;
			end
			default: next_state = SSTOP_RUN;
		endcase
		// reset source forces run
		// Outputs follow next_state, so they must see the override too
		if (reset_src)
			next_state = SSTOP_RUN;
	end

	// State register; reset wake takes its own synchronous branch that loads the same RUN value as the ordinary reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= SSTOP_RUN;
		else if (reset_src)
			state <= SSTOP_RUN;
		else
			state <= next_state;
	end

	// Oscillator wait counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wait_cnt <= 16'h0000;
		else if (state != SSTOP_WAIT)
			wait_cnt <= 16'h0000;
		else
			wait_cnt <= wait_cnt + 16'h0001;
	end

	// Capture service context at entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_from_isr <= 1'b0;
			entry_prio    <= SSTOP_PRIO_NONE;
		end else if (reset_src) begin
			stop_from_isr <= 1'b0;
			entry_prio    <= SSTOP_PRIO_NONE;
		end else if (state == SSTOP_RUN && (stop_wr || idle_wr)) begin
			stop_from_isr <= serviced_prio != SSTOP_PRIO_NONE;
			entry_prio    <= serviced_prio;
		end
	end

	// Wake cause latched for the report after the wait
	logic cause_nmi;
	logic cause_ack;
	logic leaving;
	assign leaving = (state == SSTOP_STOP || state == SSTOP_IDLE) && wake_any;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_nmi <= 1'b0;
			cause_ack <= 1'b0;
		end else if (leaving) begin
			cause_nmi <= nmi_src;
			cause_ack <= nmi_src | ~stop_from_isr | (req_prio < entry_prio);
		end
	end

	// Wake report pulse to the CPU; IDLE skips the wait, so its cause is taken live
	logic resume;
	logic wake_nmi;
	logic wake_ack;
	assign resume = !reset_src && ((state == SSTOP_WAIT && next_state == SSTOP_RUN) ||
		(state == SSTOP_IDLE && wake_any));
	assign wake_nmi = (state == SSTOP_IDLE) ? nmi_src : cause_nmi;
	assign wake_ack = (state == SSTOP_IDLE) ? (nmi_src | ~stop_from_isr | (req_prio < entry_prio)) : cause_ack;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wake <= '0;
		else if (resume) begin
			wake.ack            <= wake_ack;
			wake.to_nmi_handler <= wake_nmi;
			wake.to_handler     <= ~wake_nmi & wake_ack & interrupts_enabled_state;
			wake.next_instr     <= ~wake_nmi & ~(wake_ack & interrupts_enabled_state);
		end else
			wake <= '0;
	end

	// Clock gating outputs
	// main osc stop, sub runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_ctl <= '{main_osc_en: 1'b1, sub_osc_en: 1'b1, cpu_clk_en: 1'b1, periph_clk_en: 1'b1};
		end else begin
			clk_ctl.main_osc_en   <= next_state != SSTOP_STOP;
			clk_ctl.sub_osc_en    <= 1'b1;
			clk_ctl.cpu_clk_en    <= next_state == SSTOP_RUN;
			clk_ctl.periph_clk_en <= next_state == SSTOP_RUN || next_state == SSTOP_IDLE;
		end
	end

	// Hold flags for memory, ports and internal data
	// RAM write hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_state    <= 1'b0;
			rto_update_en <= 1'b1;
			standby_reset <= 1'b0;
		end else begin
			hold_state    <= next_state != SSTOP_RUN;
			rto_update_en <= next_state == SSTOP_RUN;
			standby_reset <= reset_src;
		end
	end

	// Serial channel enables in standby
	// async needs external clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_async_channel_en     <= 1'b1;
			clocked_serial_channels_en <= 1'b1;
		end else begin
			first_async_channel_en     <= next_state == SSTOP_RUN || clk_select[SSTOP_ASYNC_EXT_BIT];
			clocked_serial_channels_en <= next_state == SSTOP_RUN || clk_select[SSTOP_CSI_EXT_BIT];
		end
	end

	// Register writes; APB writes are taken in every state, standby included, and a reset source clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_save_mode_reg    <= 2'h0;
			power_save_control_reg <= 7'h00;
			clk_select             <= 4'h0;
			adc_mode_reg           <= 2'h0;
		end else if (reset_src) begin
			power_save_mode_reg    <= 2'h0;
			power_save_control_reg <= 7'h00;
			clk_select             <= 4'h0;
			adc_mode_reg           <= 2'h0;
		end else if (apb_wr) begin
			case (paddr)
				SSTOP_MODE_OFS:   power_save_mode_reg    <= pwdata[1:0];
				// Request bits never stored; they act as strobes
				SSTOP_CTRL_OFS:   power_save_control_reg <= pwdata[6:0] & 7'h70;
				SSTOP_CLKSEL_OFS: clk_select             <= pwdata[3:0];
				SSTOP_ADC_OFS:    adc_mode_reg           <= pwdata[1:0];
				default:          ;
			endcase
		end
	end

	// APB read and response; no wait states, unmapped reads zero with error
	logic mapped;
	assign mapped = paddr == SSTOP_MODE_OFS || paddr == SSTOP_CTRL_OFS || paddr == SSTOP_STATUS_OFS ||
		paddr == SSTOP_CLKSEL_OFS || paddr == SSTOP_ADC_OFS || paddr == SSTOP_RTO_OFS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= SSTOP_ZERO_WORD;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= SSTOP_ZERO_WORD;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					SSTOP_MODE_OFS:   prdata <= {30'h0, power_save_mode_reg};
					SSTOP_CTRL_OFS:   prdata <= {25'h0, power_save_control_reg};
					SSTOP_STATUS_OFS: prdata <= {26'h0, stop_from_isr, wake_any, state};
					SSTOP_CLKSEL_OFS: prdata <= {28'h0, clk_select};
					SSTOP_ADC_OFS:    prdata <= {30'h0, adc_mode_reg};
					SSTOP_RTO_OFS:    prdata <= {31'h0, rto_update_en};
					default:          prdata <= SSTOP_ZERO_WORD;
				endcase
			end
		end
	end

	// Entry only from run with select bit set
	property p_stop_entry;
		@(posedge pclk) disable iff (!presetn)
		(state == SSTOP_RUN && $past(state) != SSTOP_STOP) ##1 state == SSTOP_STOP |-> $past(stop_wr);
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop entered without request");

	property p_main_osc;
		@(posedge pclk) disable iff (!presetn)
		state == SSTOP_STOP && $past(state) == SSTOP_STOP |-> !clk_ctl.main_osc_en && clk_ctl.sub_osc_en;
	endproperty
	a_main_osc: assert property (p_main_osc) else $error("main osc running in stop");

	property p_cpu_clk;
		@(posedge pclk) disable iff (!presetn)
		state == SSTOP_STOP ##1 state == SSTOP_STOP |-> !clk_ctl.cpu_clk_en && !clk_ctl.periph_clk_en;
	endproperty
	a_cpu_clk: assert property (p_cpu_clk) else $error("cpu clock not cut");

	property p_masked;
		@(posedge pclk) disable iff (!presetn)
		state == SSTOP_STOP && !nmi_src && power_save_control_reg[SSTOP_MASKABLE_DIS_BIT] && !reset_src
		|=> state == SSTOP_STOP;
	endproperty
	a_masked: assert property (p_masked) else $error("masked source woke");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		state == SSTOP_STOP && wake_any |=> state == SSTOP_WAIT || state == SSTOP_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("enabled source did not wake");

	property p_osc_wait;
		@(posedge pclk) disable iff (!presetn)
		$rose(state == SSTOP_WAIT) && !reset_src |-> ##[1:300] state != SSTOP_WAIT;
	endproperty
	a_osc_wait: assert property (p_osc_wait) else $error("oscillator wait stuck");

	property p_wdt_sub;
		@(posedge pclk) disable iff (!presetn)
		!on_sub && !nmi_s[1] |-> !nmi_src;
	endproperty
	a_wdt_sub: assert property (p_wdt_sub) else $error("watchdog accepted off subclock");

	property p_nmi_branch;
		@(posedge pclk) disable iff (!presetn)
		wake.to_nmi_handler |-> wake.ack && !wake.to_handler && !wake.next_instr;
	endproperty
	a_nmi_branch: assert property (p_nmi_branch) else $error("nmi wake not to handler");

	property p_rto;
		@(posedge pclk) disable iff (!presetn)
		state == SSTOP_IDLE ##1 state == SSTOP_IDLE |-> !rto_update_en && hold_state;
	endproperty
	a_rto: assert property (p_rto) else $error("rto buffer open in idle");

	property p_reset_wake;
		@(posedge pclk) disable iff (!presetn)
		reset_src |=> state == SSTOP_RUN && power_save_mode_reg == 2'h0 && clk_select == 4'h0;
	endproperty
	a_reset_wake: assert property (p_reset_wake) else $error("reset wake differs from reset");

endmodule

// [bench/sstop_cpu_model.sv]
// CPU core and interrupt controller model facing the standby controller
`timescale 1ns/1ps
module sstop_cpu_model
	import sstop_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Context set by the bench
	input  wire logic       req_in,
	input  wire logic [3:0] req_prio_cfg,
	input  wire logic [3:0] isr_prio_cfg,
	input  wire logic       ie_cfg,
	// Wake report from the controller
	input  sstop_wake_t     wake,
	// Context seen by the controller, and the pending flag seen by the bench
	output logic [3:0]      req_prio,
	output logic [3:0]      serviced_prio,
	output logic            interrupts_enabled_state,
	output logic            pending
);
	// Interrupt context, registered like the real core state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_prio <= SSTOP_PRIO_NONE;
			serviced_prio <= SSTOP_PRIO_NONE;
			interrupts_enabled_state <= 1'b0;
		end else begin
			req_prio <= req_prio_cfg;
			serviced_prio <= isr_prio_cfg;
			interrupts_enabled_state <= ie_cfg;
		end
	end
	// pending until acknowledged
	// Only an acknowledge or presetn clears it, so a low priority wake leaves it set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= 1'b0;
		end else if (wake.ack) begin
			pending <= 1'b0;
		end else if (req_in) begin
			pending <= 1'b1;
		end
	end
endmodule

// [bench/tb.sv]
// Self-checking bench for the standby controller
`timescale 1ns/1ps
module tb
	import sstop_pkg::*;
;
	localparam int OSC = 4;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd_v;
	logic        pready, pslverr, er_v, pending, standby_reset, hold_state;
	logic        nmi_pin = 0, reset_pin_n = 1, second_watchdog_irq = 0, ie_cfg = 1, wdt_rst = 0;
	logic [6:0]  external_irq_pins = 0;
	logic [7:0]  periph_irq = 0;
	logic [3:0]  req_prio, serviced_prio, rprio = 4'hf, iprio = 4'hf;
	logic        interrupts_enabled_state, rto_update_en, first_async_channel_en, clocked_serial_channels_en;
	sstop_clk_t  clk_ctl;
	sstop_wake_t wake, w;
	int          fail_count = 0, num_checks = 0, c;

	always #2.5 pclk = ~pclk;

	// Design under test with a short oscillator wait
	sstop_ctrl #(.OSC_WAIT_CYC(OSC)) u_sstop_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin), .external_irq_pins(external_irq_pins),
		.reset_pin_n(reset_pin_n), .periph_irq(periph_irq), .second_watchdog_irq(second_watchdog_irq),
		.second_watchdog_reset(wdt_rst), .req_prio(req_prio), .serviced_prio(serviced_prio),
		.interrupts_enabled_state(interrupts_enabled_state), .clk_ctl(clk_ctl), .wake(wake),
		.standby_reset(standby_reset), .hold_state(hold_state), .rto_update_en(rto_update_en),
		.first_async_channel_en(first_async_channel_en),
		.clocked_serial_channels_en(clocked_serial_channels_en));

	// CPU side partner
	sstop_cpu_model u_sstop_cpu_model (.pclk(pclk), .presetn(presetn), .req_in(periph_irq[0]),
		.req_prio_cfg(rprio), .isr_prio_cfg(iprio), .ie_cfg(ie_cfg), .wake(wake), .req_prio(req_prio),
		.serviced_prio(serviced_prio), .interrupts_enabled_state(interrupts_enabled_state),
		.pending(pending));

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wrt, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wrt;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		er_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic src(input int s, input logic v);
		case (s)
			0: nmi_pin <= v;
			1: external_irq_pins[0] <= v;
			2: periph_irq[0] <= v;
			default: second_watchdog_irq <= v;
		endcase
	endtask

	// Bounded wait for RUN; 400 means no wake
	task automatic wait_run();
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while (hold_state !== 1'b0 && c < 400);
		w = wake;
	endtask

	task automatic stop_wake(input int s, input logic [31:0] ctl);
		apb(1, SSTOP_CTRL_OFS, ctl);
		repeat (5) @(posedge pclk);
		src(s, 1'b1);
		wait_run();
		src(s, 1'b0);
	endtask

	task automatic t_reset();
		chk("clk", clk_ctl, 4'hf);
		chk("rto", rto_update_en, 1'b1);
		apb(0, 12'h100, 32'h0);
		chk("unmapped err", er_v, 1'b1);
		apb(0, SSTOP_CTRL_OFS, 32'h0);
		chk("ctrl", rd_v, 32'h0);
		chk("ctrl err", er_v, 1'b0);
		apb(1, SSTOP_CTRL_OFS, 32'h2);
		apb(0, SSTOP_STATUS_OFS, 32'h0);
		chk("state nosel", rd_v[3:0], 4'h1);
		apb(1, SSTOP_MODE_OFS, 32'h1);
	endtask

	task automatic t_stop();
		apb(1, SSTOP_CTRL_OFS, 32'h2);
		repeat (2) @(posedge pclk);
		chk("stop clk", clk_ctl, 4'h4);
		chk("hold", hold_state, 1'b1);
		apb(0, SSTOP_STATUS_OFS, 32'h0);
		chk("state stop", rd_v[3:0], 4'h2);
		src(0, 1'b1);
		wait_run();
		src(0, 1'b0);
		chk("osc wait", c > OSC, 1'b1);
		chk("nmi vec", w.to_nmi_handler, 1'b1);
		chk("nmi ack", w.ack, 1'b1);
		chk("run clk", clk_ctl, 4'hf);
	endtask

	task automatic t_mask();
		stop_wake(1, 32'h12);
		chk("masked", c, 400);
		src(0, 1'b1);
		wait_run();
		src(0, 1'b0);
		stop_wake(1, 32'h2);
		chk("pin wake", c < 400, 1'b1);
		chk("pin ack", w.ack, 1'b1);
		chk("pin vec", w.to_handler, 1'b1);
	endtask

	task automatic t_prio();
		iprio <= 4'h2;
		rprio <= 4'h5;
		stop_wake(2, 32'h2);
		chk("low ack", w.ack, 1'b0);
		chk("pending", pending, 1'b1);
		rprio <= 4'h1;
		stop_wake(2, 32'h2);
		chk("high ack", w.ack, 1'b1);
		@(posedge pclk);
		chk("ack clears", pending, 1'b0);
		iprio <= 4'hf;
		ie_cfg <= 1'b0;
		stop_wake(2, 32'h2);
		chk("di next", w.next_instr, 1'b1);
		ie_cfg <= 1'b1;
	endtask

	task automatic t_wdt();
		stop_wake(3, 32'h2);
		chk("wdt main", c, 400);
		src(0, 1'b1);
		wait_run();
		src(0, 1'b0);
		apb(1, SSTOP_CLKSEL_OFS, 32'h1);
		stop_wake(3, 32'h2);
		chk("wdt sub", w.to_nmi_handler, 1'b1);
		// Watchdog reset clears the subclock select, so it drops itself
		wdt_rst <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("wdt rst sub", standby_reset, 1'b1);
		repeat (2) @(posedge pclk);
		chk("wdt rst main", standby_reset, 1'b0);
		wdt_rst <= 1'b0;
		apb(0, SSTOP_CLKSEL_OFS, 32'h0);
		chk("wdt rst clksel", rd_v, 32'h0);
	endtask

	task automatic t_rst();
		apb(1, SSTOP_MODE_OFS, 32'h1);
		apb(1, SSTOP_CTRL_OFS, 32'h2);
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("rst src", standby_reset, 1'b1);
		reset_pin_n <= 1'b1;
		wait_run();
		repeat (4) @(posedge pclk);
		chk("rst clk", clk_ctl, 4'hf);
		apb(0, SSTOP_MODE_OFS, 32'h0);
		chk("rst mode", rd_v, 32'h0);
	endtask

	task automatic t_idle();
		apb(1, SSTOP_ADC_OFS, 32'h3);
		apb(0, SSTOP_ADC_OFS, 32'h0);
		chk("adc set", rd_v, 32'h3);
		apb(1, SSTOP_ADC_OFS, 32'h0);
		apb(0, SSTOP_ADC_OFS, 32'h0);
		chk("adc clear", rd_v, 32'h0);
		apb(1, SSTOP_MODE_OFS, 32'h2);
		apb(1, SSTOP_CTRL_OFS, 32'h4);
		repeat (2) @(posedge pclk);
		chk("idle rto", rto_update_en, 1'b0);
		chk("idle async", first_async_channel_en, 1'b0);
		chk("idle csi", clocked_serial_channels_en, 1'b0);
		chk("idle hold", hold_state, 1'b1);
		apb(1, SSTOP_CLKSEL_OFS, 32'h6);
		repeat (2) @(posedge pclk);
		chk("ext async", first_async_channel_en, 1'b1);
		chk("ext csi", clocked_serial_channels_en, 1'b1);
		apb(0, SSTOP_MODE_OFS, 32'h0);
		chk("idle mode", rd_v, 32'h2);
		apb(0, SSTOP_RTO_OFS, 32'h0);
		chk("rto reg", rd_v, 32'h0);
		src(0, 1'b1);
		wait_run();
		src(0, 1'b0);
		chk("idle wake", c < 400, 1'b1);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, well above the expected run length
	initial begin
		#100000;
		fail_count++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_reset();
		t_stop();
		t_mask();
		t_prio();
		t_wdt();
		t_rst();
		t_idle();
		conclude();
	end
endmodule
